/* File: link_engine_model.sv */
// Link engine model issuing pointer, write and read requests
`timescale 1ns/100ps
module link_engine_model
  import sensor_regs_pkg::*;
(
  input wire logic link_clk,
  input wire logic link_busy_r,
  input wire logic link_rsp_valid_r,
  input link_rsp_type link_rsp_r,
  output logic link_req_valid,
  output link_req_type link_req
);
  initial begin
    link_req_valid = 1'b0;
    link_req = '{OP_PTR, 8'h5a};
  end
  // One request outstanding; held until the edge that takes it
  task automatic xfer(input link_op_type op, input logic [7:0] d,
                      output link_rsp_type r, output logic ok, output logic bz);
    int n;
    ok = 1'b0;
    bz = 1'b0;
    r = '0;
    n = 0;
    @(posedge link_clk);
    link_req_valid <= 1'b1;
    link_req <= '{op, d};
    do begin
      @(posedge link_clk);
      n++;
    end while (link_busy_r === 1'b1 && n < 16);
    link_req_valid <= 1'b0;
    // Released data must not keep showing the last byte
    link_req.data <= ~d;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge link_clk);
      if (link_busy_r === 1'b1) begin
        bz = 1'b1;
      end
      if (link_rsp_valid_r === 1'b1) begin
        r = link_rsp_r;
        ok = 1'b1;
      end
    end
  endtask
endmodule

/* File: sensor_regs_pkg.sv */
// Constants and carriers for the sensor result and status register bank
// How it works
// RQ1 - Results are 16-bit codes over two bytes; two lowest bits always read zero
// RQ2 - Result bits below the chosen resolution are masked; field stays 16 bits
// RQ3 - Host reads temperature low byte before high byte
// RQ4 - Host reads humidity low byte before high byte
// RQ5 - Temperature code is stored as given: C = code/65536*165-40
// RQ6 - Humidity code is stored as given: %RH = code/65536*100
// RQ7 - Status holds done, temp over/under, humid over/under at bits 7..3
// RQ8 - Conversion done flag sets when a conversion finishes
// RQ9 - Done flag clears on reading status or any of the four result bytes
// RQ10 - Threshold flags set on limit exceeded, latched or following per mode
// RQ11 - Reading status clears all four threshold flags; with thr_follow set the code keeps them equal to the limits instead
// RQ12 - Alert pin follows enabled flags per polarity and enable setting
// RQ13 - Temperature peak keeps highest converted temperature high byte
// RQ14 - Humidity peak keeps highest converted humidity high byte
// RQ15 - Both peaks clear at reset and on soft reset
// RQ16 - Peaks do not track in automatic measurement mode
// RQ17 - Peak bytes use the high byte of the code, same scaling
// RQ18 - Enable register holds the five enables at bits 7..3
// RQ19 - Register pointer advances after every byte read or written
// RQ20 - A flag event in the clearing cycle survives the clear
package sensor_regs_pkg;
  localparam logic [7:0] ADDR_TEMP_LO = 8'h00;
  localparam logic [7:0] ADDR_TEMP_HI = 8'h01;
  localparam logic [7:0] ADDR_HUM_LO = 8'h02;
  localparam logic [7:0] ADDR_HUM_HI = 8'h03;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TPEAK = 8'h05;
  localparam logic [7:0] ADDR_HPEAK = 8'h06;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h07;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] FLAG_MASK = 8'hf8;
  localparam int FLAG_LSB = 3;
  localparam int BIT_DONE = 7;
  localparam int BIT_TOVER = 6;
  localparam int BIT_TUNDER = 5;
  localparam int BIT_HOVER = 4;
  localparam int BIT_HUNDER = 3;
  localparam logic [1:0] RES_14 = 2'h0;
  localparam logic [1:0] RES_11 = 2'h1;
  localparam logic [15:0] MASK_14 = 16'hfffc;
  localparam logic [15:0] MASK_11 = 16'hffe0;
  localparam logic [15:0] MASK_9 = 16'hff80;
  typedef enum logic [1:0] {
    OP_PTR = 2'b00,
    OP_WR = 2'b01,
    OP_RD = 2'b10
  } link_op_type;
  typedef enum logic {
    LINK_IDLE = 1'b0,
    LINK_WAIT = 1'b1
  } link_state_type;
  typedef struct packed {
    link_op_type op;
    logic [7:0] data;
  } link_req_type;
  typedef struct packed {
    logic [7:0] data;
    logic nack;
  } link_rsp_type;
  typedef struct packed {
    logic done;
    logic has_temp;
    logic has_humid;
    logic [15:0] temp;
    logic [15:0] humid;
  } conv_type;
  typedef struct packed {
    logic temp_over;
    logic temp_under;
    logic humid_over;
    logic humid_under;
  } limit_type;
endpackage

/* File: sensor_result_status_registers.sv */
// Result, status, peak and enable registers behind the link pointer port
`timescale 1ns/100ps
module sensor_result_status_registers
  import sensor_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic link_req_valid,
  input link_req_type link_req,
  output logic link_busy_r,
  output logic link_rsp_valid_r,
  output link_rsp_type link_rsp_r,
  input conv_type conv,
  input limit_type limits,
  input wire logic [1:0] res_sel,
  input wire logic auto_mode,
  input wire logic soft_reset,
  input wire logic thr_follow,
  input wire logic alert_enable,
  input wire logic alert_polarity,
  output logic alert_output_pin_r,
  output logic alert_pin_oe_r
);

  // Link side: reset brought over, request held until answered
  logic [1:0] link_rst_r;
  link_state_type link_state_r;
  logic req_tgl_r;
  link_req_type req_hold_r;
  logic [2:0] ack_sync_r;
  logic ack_tgl_r;
  link_rsp_type rsp_r;
  wire ack_seen = ack_sync_r[2] ^ ack_sync_r[1];

  always_ff @(posedge link_clk) begin
    link_rst_r <= {link_rst_r[0], reset};
  end

  always_ff @(posedge link_clk) begin
    if (link_rst_r[1]) begin
      ack_sync_r <= 3'h0;
    end else begin
      ack_sync_r <= {ack_sync_r[1:0], ack_tgl_r};
    end
  end

  // New requests while waiting are dropped; busy tells the engine
  always_ff @(posedge link_clk) begin
    if (link_rst_r[1]) begin
      link_state_r <= LINK_IDLE;
      link_busy_r <= 1'b0;
      req_tgl_r <= 1'b0;
      req_hold_r <= '0;
    end else begin
      case (link_state_r)
        LINK_IDLE: begin
          if (link_req_valid) begin
            req_hold_r <= link_req;
            req_tgl_r <= ~req_tgl_r;
            link_state_r <= LINK_WAIT;
            link_busy_r <= 1'b1;
          end
        end
        LINK_WAIT: begin
          if (ack_seen) begin
            link_state_r <= LINK_IDLE;
            link_busy_r <= 1'b0;
          end
        end
        default: begin
          link_state_r <= LINK_IDLE;
          link_busy_r <= 1'b0;
        end
      endcase
    end
  end

  // Answer data is stable in rsp_r before the ack toggle crosses
  always_ff @(posedge link_clk) begin
    if (link_rst_r[1]) begin
      link_rsp_valid_r <= 1'b0;
      link_rsp_r <= '0;
    end else begin
      link_rsp_valid_r <= ack_seen;
      if (ack_seen) begin
        link_rsp_r <= rsp_r;
      end
    end
  end

  // System side
  logic [2:0] req_sync_r;
  logic [7:0] ptr_r;
  logic [15:0] temp_r;
  logic [15:0] humid_r;
  logic [7:0] temp_hi_hold_r;
  logic [7:0] hum_hi_hold_r;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] tpeak_r;
  logic [7:0] hpeak_r;
  logic [7:0] irq_en_r;
  logic [15:0] res_mask;
  logic [15:0] temp_cut;
  logic [15:0] hum_cut;
  logic [7:0] rd_data;
  logic rd_nack;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      req_sync_r <= 3'h0;
    end else begin
      req_sync_r <= {req_sync_r[1:0], req_tgl_r};
    end
  end

  wire req_seen = req_sync_r[2] ^ req_sync_r[1];
  wire do_ptr = req_seen && req_hold_r.op == OP_PTR;
  wire do_wr = req_seen && req_hold_r.op == OP_WR;
  wire do_rd = req_seen && req_hold_r.op == OP_RD;
  wire rd_status = do_rd && ptr_r == ADDR_STATUS;
  wire rd_result = do_rd && ptr_r <= ADDR_HUM_HI;
  wire take_temp = conv.done && conv.has_temp;
  wire take_hum = conv.done && conv.has_humid;
  wire peak_ok = !auto_mode;

  // Resolution masking; two lowest bits always cleared
  always_comb begin
    case (res_sel)
      RES_14: res_mask = MASK_14;
      RES_11: res_mask = MASK_11;
      default: res_mask = MASK_9;
    endcase
    temp_cut = conv.temp & res_mask; // see RQ1 see RQ2
    hum_cut = conv.humid & res_mask; // see RQ1 see RQ2
  end

  // Pointer loads or steps after each data byte
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ptr_r <= RESET_BYTE;
    end else if (do_ptr) begin
      ptr_r <= req_hold_r.data;
    end else if (do_wr || do_rd) begin
      ptr_r <= ptr_r + 8'h01; // see RQ19
    end
  end

  // Codes stored unscaled; the host applies the conversion formulas
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      temp_r <= '0;
      humid_r <= '0;
    end else begin
      if (take_temp) begin
        temp_r <= temp_cut; // see RQ5
      end
      if (take_hum) begin
        humid_r <= hum_cut; // see RQ6
      end
    end
  end

  // High byte frozen at the low-byte read so a pair never tears
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      temp_hi_hold_r <= RESET_BYTE;
      hum_hi_hold_r <= RESET_BYTE;
    end else begin
      if (do_rd && ptr_r == ADDR_TEMP_LO) begin
        temp_hi_hold_r <= temp_r[15:8]; // see RQ3
      end
      if (do_rd && ptr_r == ADDR_HUM_LO) begin
        hum_hi_hold_r <= humid_r[15:8]; // see RQ4
      end
    end
  end

  // Flags: set wins over a read clear in the same cycle
  always_comb begin
    flags_nxt = flags_r & FLAG_MASK;
    if (rd_status || rd_result) begin
      flags_nxt[BIT_DONE] = 1'b0; // see RQ9
    end
    if (rd_status) begin
      flags_nxt[BIT_TOVER:BIT_HUNDER] = '0; // see RQ11
    end
    if (conv.done) begin
      flags_nxt[BIT_DONE] = 1'b1; // see RQ8 see RQ20
    end
    if (thr_follow) begin
      flags_nxt[BIT_TOVER:BIT_HUNDER] = limits; // see RQ10
    end else begin
      flags_nxt[BIT_TOVER:BIT_HUNDER] =
        flags_nxt[BIT_TOVER:BIT_HUNDER] | limits; // see RQ10 see RQ20
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flags_r <= RESET_BYTE; // see RQ7
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Peaks: soft reset first, then conversions, then host writes
  always_ff @(posedge sys_clk) begin
    if (reset || soft_reset) begin
      tpeak_r <= RESET_BYTE; // see RQ15
      hpeak_r <= RESET_BYTE; // see RQ15
    end else begin
      if (take_temp && peak_ok && temp_cut[15:8] > tpeak_r) begin
        tpeak_r <= temp_cut[15:8]; // see RQ13 see RQ16 see RQ17
      end else if (do_wr && ptr_r == ADDR_TPEAK) begin
        tpeak_r <= req_hold_r.data;
      end
      if (take_hum && peak_ok && hum_cut[15:8] > hpeak_r) begin
        hpeak_r <= hum_cut[15:8]; // see RQ14 see RQ16 see RQ17
      end else if (do_wr && ptr_r == ADDR_HPEAK) begin
        hpeak_r <= req_hold_r.data;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_en_r <= RESET_BYTE;
    end else if (do_wr && ptr_r == ADDR_IRQ_EN) begin
      irq_en_r <= req_hold_r.data & FLAG_MASK; // see RQ18
    end
  end

  // Read mux; unmapped reads and read-only writes are refused
  always_comb begin
    rd_data = RESET_BYTE;
    rd_nack = 1'b0;
    case (ptr_r)
      ADDR_TEMP_LO: rd_data = temp_r[7:0];
      ADDR_TEMP_HI: rd_data = temp_hi_hold_r;
      ADDR_HUM_LO: rd_data = humid_r[7:0];
      ADDR_HUM_HI: rd_data = hum_hi_hold_r;
      ADDR_STATUS: rd_data = flags_r;
      ADDR_TPEAK: rd_data = tpeak_r;
      ADDR_HPEAK: rd_data = hpeak_r;
      ADDR_IRQ_EN: rd_data = irq_en_r;
      default: rd_nack = 1'b1;
    endcase
    if (req_hold_r.op == OP_WR && ptr_r < ADDR_TPEAK) begin
      rd_nack = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_tgl_r <= 1'b0;
      rsp_r <= '0;
    end else if (req_seen) begin
      ack_tgl_r <= ~ack_tgl_r;
      rsp_r.data <= do_rd ? rd_data : RESET_BYTE;
      rsp_r.nack <= do_ptr ? 1'b0 : rd_nack;
    end
  end

  // Alert pin; released when alert output is disabled
  wire alert_active = |(flags_r & irq_en_r);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      alert_output_pin_r <= 1'b0;
      alert_pin_oe_r <= 1'b0;
    end else begin
      alert_output_pin_r <= alert_polarity ? alert_active : ~alert_active; // see RQ12
      alert_pin_oe_r <= alert_enable; // see RQ12
    end
  end

  // Checks
  sequence s_status_read;
    rd_status && !conv.done && !thr_follow && limits == '0;
  endsequence

  sequence s_result_update;
    take_temp && !auto_mode && temp_cut[15:8] > tpeak_r && !soft_reset;
  endsequence

  property p_low_bits;
    @(posedge sys_clk) disable iff (reset)
      temp_r[1:0] == 2'b00 && humid_r[1:0] == 2'b00;
  endproperty
  a_low_bits: assert property (p_low_bits) // see RQ1
    else $error("result low bits not zero");

  property p_res11;
    @(posedge sys_clk) disable iff (reset)
      take_temp && res_sel == RES_11 |=> temp_r[4:0] == 5'h00;
  endproperty
  a_res11: assert property (p_res11) // see RQ2
    else $error("11-bit result not masked");

  property p_done_set;
    @(posedge sys_clk) disable iff (reset)
      conv.done |=> flags_r[BIT_DONE] ##1 (flags_r[BIT_DONE] || $past(rd_status || rd_result));
  endproperty
  a_done_set: assert property (p_done_set) // see RQ8
    else $error("done flag not set");

  property p_status_clear;
    @(posedge sys_clk) disable iff (reset)
      s_status_read |=> flags_r == RESET_BYTE;
  endproperty
  a_status_clear: assert property (p_status_clear) // see RQ11
    else $error("status read did not clear flags");

  property p_result_clear;
    @(posedge sys_clk) disable iff (reset)
      rd_result && !conv.done |=> !flags_r[BIT_DONE];
  endproperty
  a_result_clear: assert property (p_result_clear) // see RQ9
    else $error("result read did not clear done");

  property p_set_wins;
    @(posedge sys_clk) disable iff (reset)
      rd_status && conv.done |=> flags_r[BIT_DONE];
  endproperty
  a_set_wins: assert property (p_set_wins) // see RQ20
    else $error("event lost in clearing cycle");

  property p_peak_track;
    @(posedge sys_clk) disable iff (reset)
      s_result_update |=> tpeak_r == $past(temp_cut[15:8]);
  endproperty
  a_peak_track: assert property (p_peak_track) // see RQ13
    else $error("temperature peak not updated");

  property p_peak_auto;
    @(posedge sys_clk) disable iff (reset)
      auto_mode && !soft_reset && !do_wr |=> $stable(tpeak_r) && $stable(hpeak_r);
  endproperty
  a_peak_auto: assert property (p_peak_auto) // see RQ16
    else $error("peak moved in automatic mode");

  property p_soft_clear;
    @(posedge sys_clk) disable iff (reset)
      soft_reset |=> tpeak_r == RESET_BYTE && hpeak_r == RESET_BYTE;
  endproperty
  a_soft_clear: assert property (p_soft_clear) // see RQ15
    else $error("soft reset left a peak");

  property p_ptr_step;
    @(posedge sys_clk) disable iff (reset)
      do_rd |=> ptr_r == $past(ptr_r) + 8'h01;
  endproperty
  a_ptr_step: assert property (p_ptr_step) // see RQ19
    else $error("pointer did not advance");

  property p_alert;
    @(posedge sys_clk) disable iff (reset)
      (alert_polarity && alert_active) [*2] |-> alert_output_pin_r;
  endproperty
  a_alert: assert property (p_alert) // see RQ12
    else $error("alert pin not following flags");

  property p_reserved;
    @(posedge sys_clk) disable iff (reset)
      flags_r[2:0] == 3'h0 && irq_en_r[2:0] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) // see RQ7 see RQ18
    else $error("reserved bits set");

endmodule

/* File: tb_top.sv */
// Self-checking bench for the result and status register bank
`timescale 1ns/100ps
module tb_top;
  import sensor_regs_pkg::*;
  logic sys_clk, reset, link_clk, link_req_valid, link_busy_r, link_rsp_valid_r;
  logic auto_mode, soft_reset, thr_follow, alert_enable, alert_polarity;
  logic alert_output_pin_r, alert_pin_oe_r;
  logic [1:0] res_sel;
  link_req_type link_req;
  link_rsp_type link_rsp_r;
  conv_type conv;
  limit_type limits;
  int n_fail = 0;
  int samples_checked = 0;
  typedef struct packed {
    logic [1:0] res;
    logic [15:0] t, h, et, eh;
  } row_type;
  row_type rows [3] = '{'{2'h0, 16'h1237, 16'habcd, 16'h1234, 16'habcc},
                        '{2'h2, 16'h8fff, 16'hffff, 16'h8f80, 16'hff80},
                        '{2'h1, 16'h1237, 16'h0fff, 16'h1220, 16'h0fe0}};

  sensor_result_status_registers sensor_result_status_registers_inst (
    .sys_clk, .reset, .link_clk, .link_req_valid, .link_req, .link_busy_r,
    .link_rsp_valid_r, .link_rsp_r, .conv, .limits, .res_sel, .auto_mode,
    .soft_reset, .thr_follow, .alert_enable, .alert_polarity,
    .alert_output_pin_r, .alert_pin_oe_r);
  link_engine_model link_engine_model_inst (
    .link_clk, .link_busy_r, .link_rsp_valid_r, .link_rsp_r, .link_req_valid,
    .link_req);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Odd start offset keeps the two clocks out of phase
  initial begin
    link_clk = 1'b0;
    #7;
    forever #62.5 link_clk = ~link_clk;
  end

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic xfer(link_op_type op, logic [7:0] d, logic [7:0] exp, logic nk,
                      string what);
    link_rsp_type r;
    logic ok, bz;
    link_engine_model_inst.xfer(op, d, r, ok, bz);
    if (!ok) begin
      n_fail++;
      complete_run();
    end else begin
      if (op == OP_RD) check(what, r.data, exp);
      check({what, " nack"}, {7'h0, r.nack}, {7'h0, nk});
      check({what, " busy"}, {7'h0, bz}, 8'h01);
      check({what, " idle"}, {7'h0, link_busy_r}, 8'h00);
    end
  endtask
  task automatic setp(logic [7:0] a);
    xfer(OP_PTR, a, 8'h00, 1'b0, "pointer");
  endtask
  task automatic rd(logic [7:0] exp, string what);
    xfer(OP_RD, 8'h00, exp, 1'b0, what);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d, logic nk);
    setp(a);
    xfer(OP_WR, d, 8'h00, nk, "write");
  endtask
  task automatic pin(logic e, string what);
    repeat (3) @(posedge sys_clk);
    check(what, {7'h0, alert_output_pin_r}, {7'h0, e});
  endtask
  task automatic convert(logic [15:0] t, logic [15:0] h, logic [1:0] res);
    @(posedge sys_clk);
    res_sel <= res;
    conv <= '{1'b1, 1'b1, 1'b1, t, h};
    @(posedge sys_clk);
    conv.done <= 1'b0;
  endtask

  initial begin
    logic [7:0] tpk, hpk, pat;
    reset = 1'b1;
    conv = '0;
    limits = '0;
    res_sel = RES_14;
    auto_mode = 1'b0;
    soft_reset = 1'b0;
    thr_follow = 1'b0;
    alert_enable = 1'b1;
    alert_polarity = 1'b1;
    tpk = 8'h00;
    hpk = 8'h00;
    // Long enough for the link side to see it through its synchroniser
    repeat (25) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge link_clk);
    check("oe", {7'h0, alert_pin_oe_r}, 8'h01);
    setp(ADDR_TEMP_LO);
    for (int a = 0; a < 8; a++) rd(RESET_BYTE, "reset value");
    wr(ADDR_IRQ_EN, 8'h80, 1'b0);
    foreach (rows[i]) begin
      convert(rows[i].t, rows[i].h, rows[i].res);
      pin(1'b1, "done pin");
      if (rows[i].et[15:8] > tpk) tpk = rows[i].et[15:8];
      if (rows[i].eh[15:8] > hpk) hpk = rows[i].eh[15:8];
      // Low byte first
      setp(ADDR_TEMP_LO);
      rd(rows[i].et[7:0], "temp lo");
      pin(1'b0, "done cleared");
      rd(rows[i].et[15:8], "temp hi");
      rd(rows[i].eh[7:0], "hum lo");
      rd(rows[i].eh[15:8], "hum hi");
      rd(8'h00, "status");
      rd(tpk, "temp peak");
      rd(hpk, "hum peak");
    end
    for (int j = 0; j < 4; j++) begin
      pat = 8'h08 << j;
      wr(ADDR_IRQ_EN, pat, 1'b0);
      setp(ADDR_IRQ_EN);
      rd(pat, "enables");
      @(posedge sys_clk);
      limits <= limit_type'(4'h1 << j);
      @(posedge sys_clk);
      limits <= '0;
      pin(1'b1, "flag pin");
      setp(ADDR_STATUS);
      rd(pat, "flag set");
      setp(ADDR_STATUS);
      rd(8'h00, "flag clear");
      pin(1'b0, "flag pin clear");
    end
    @(posedge sys_clk);
    thr_follow <= 1'b1;
    limits <= limit_type'(4'h9);
    setp(ADDR_STATUS);
    rd(8'h48, "follow");
    setp(ADDR_STATUS);
    rd(8'h48, "follow held");
    @(posedge sys_clk);
    alert_polarity <= 1'b0;
    pin(1'b0, "low polarity");
    alert_enable <= 1'b0;
    thr_follow <= 1'b0;
    limits <= '0;
    pin(1'b0, "idle pin");
    check("oe off", {7'h0, alert_pin_oe_r}, 8'h00);
    wr(ADDR_TEMP_LO, 8'h55, 1'b1);
    setp(8'h08);
    xfer(OP_RD, 8'h00, 8'h00, 1'b1, "unmapped");
    wr(ADDR_TPEAK, 8'h3c, 1'b0);
    setp(ADDR_TPEAK);
    rd(8'h3c, "peak write");
    @(posedge sys_clk);
    soft_reset <= 1'b1;
    @(posedge sys_clk);
    soft_reset <= 1'b0;
    setp(ADDR_TPEAK);
    rd(8'h00, "soft reset tpeak");
    rd(8'h00, "soft reset hpeak");
    @(posedge sys_clk);
    auto_mode <= 1'b1;
    convert(16'hf000, 16'hf000, RES_14);
    setp(ADDR_TPEAK);
    rd(8'h00, "auto tpeak");
    rd(8'h00, "auto hpeak");
    @(posedge sys_clk);
    auto_mode <= 1'b0;
    convert(16'h2000, 16'h4000, RES_14);
    setp(ADDR_TPEAK);
    rd(8'h20, "new tpeak");
    rd(8'h40, "new hpeak");
    // Done held across a status read so the clear and the set meet
    @(posedge sys_clk);
    conv.done <= 1'b1;
    setp(ADDR_STATUS);
    rd(8'hc8, "set wins");
    @(posedge sys_clk);
    conv.done <= 1'b0;
    setp(ADDR_STATUS);
    rd(8'h80, "done kept");
    complete_run();
  end
endmodule
